// >>> logic/tsi_defs.svh
// Register offsets, field positions, reset values and timing counts of the touch sense block
`ifndef TSI_DEFS_SVH
`define TSI_DEFS_SVH

`define TSI_REG_STATUS   8'h02
`define TSI_REG_AFE      8'h41
`define TSI_REG_FILT     8'h43
`define TSI_REG_ELEN     8'h5e

`define TSI_AFE_RST      8'h10
`define TSI_FILT_RST     8'h24
`define TSI_ELEN_RST     4'h0

`define TSI_CDC_MSB      5
`define TSI_CDC_LSB      0
`define TSI_FFI_MSB      7
`define TSI_FFI_LSB      6
`define TSI_CDT_MSB      7
`define TSI_CDT_LSB      5
`define TSI_ELEN_MSB     3

`define TSI_FFI_N0       6'h06
`define TSI_FFI_N1       6'h0a
`define TSI_FFI_N2       6'h12
`define TSI_FFI_N3       6'h22

// Bus address of the device, value is arbitrary
`define TSI_I2C_ADDR     7'h2c
`define TSI_TOUCH_LEVEL  10'h1ff

`define TSI_CLK_MHZ      20
`define TSI_CHG_BASE_NS  500
`define TSI_CHG_BASE_CYC ((`TSI_CHG_BASE_NS * `TSI_CLK_MHZ + 999) / 1000)

`endif

// >>> logic/tsi_pkg.sv
// Types shared by the touch sense block
package tsi_pkg;
  typedef enum logic [2:0] {S_IDLE, S_GND, S_CHG, S_CONV, S_DIS} tsi_seq_t;
  typedef enum logic [2:0] {B_IDLE, B_ADDR, B_ACKA, B_WDATA, B_ACKW, B_RDATA, B_ACKR} tsi_bus_t;
  typedef struct packed {
    logic [1:0] ch;
  } tsi_adc_req_t;
  typedef struct packed {
    logic [9:0] data;
  } tsi_adc_rsp_t;
endpackage

// >>> logic/tsi_adc_xfer.sv
// Crossing between the sequencer clock and the converter clock
`timescale 1ns/10ps
`default_nettype none
module tsi_adc_xfer (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  afe_clk,
  input  wire logic                  req_tgl,
  input  wire tsi_pkg::tsi_adc_req_t req,
  output logic                       done,
  output tsi_pkg::tsi_adc_rsp_t      rsp,
  output logic                       adc_sample,
  output logic [1:0]                 adc_ch,
  input  wire logic [9:0]            adc_data
);
  import tsi_pkg::*;

  logic       rq_s1_r, rq_s2_r, rq_s3_r;
  logic       ak_tgl_r;
  logic [9:0] word_r;
  logic       ak_s1_r, ak_s2_r, ak_s3_r;
  wire        rq_edge = rq_s2_r ^ rq_s3_r;
  wire        ak_edge = ak_s2_r ^ ak_s3_r;

  // Converter side: request toggle synchronised, sample pulse, word captured one edge later
  always_ff @(posedge afe_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_s1_r    <= 1'b0;
      rq_s2_r    <= 1'b0;
      rq_s3_r    <= 1'b0;
      adc_sample <= 1'b0;
      adc_ch     <= 2'h0;
      ak_tgl_r   <= 1'b0;
      word_r     <= 10'h000;
    end else begin
      rq_s1_r    <= req_tgl;
      rq_s2_r    <= rq_s1_r;
      rq_s3_r    <= rq_s2_r;
      adc_sample <= rq_edge;
      if (rq_edge) begin
        adc_ch <= req.ch;
      end
      if (adc_sample) begin
        word_r   <= adc_data;
        ak_tgl_r <= ~ak_tgl_r;
      end
    end
  end

  // Sequencer side: answer toggle synchronised, word held stable while it is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ak_s1_r  <= 1'b0;
      ak_s2_r  <= 1'b0;
      ak_s3_r  <= 1'b0;
      done     <= 1'b0;
      rsp.data <= 10'h000;
    end else begin
      ak_s1_r <= ak_tgl_r;
      ak_s2_r <= ak_s1_r;
      ak_s3_r <= ak_s2_r;
      done    <= ak_edge;
      if (ak_edge) begin
        rsp.data <= word_r;
      end
    end
  end

  sample_cap_a: assert property (@(posedge afe_clk) disable iff (!rst_n)
    adc_sample |=> (ak_tgl_r != $past(ak_tgl_r)) && (word_r == $past(adc_data)))
    else $error("Converter word not captured after sample");
endmodule
`default_nettype wire

// >>> logic/tsi_top.sv
// Touch sense controller: bus slave, measurement sequencer and latching interrupt
// Operation
// - Any touch status change raises the interrupt
// - Touch and release both count as change
// - Any read transaction releases the interrupt
// - Interrupt pin active low, open drain, latched
// - Electrode grounded before each measurement
// - Other electrodes grounded while one measures
// - Charge for set time, then 10-bit sample
// - Discharge to ground for the charge time
// - Charge time 500 ns to 32 us
// - Charge current n uA, code 0 disables
// - Sample count 6, 10, 18 or 34
// - Front end configuration at address 0x41
// - One touch status bit per electrode
// - Electrode enable field selects mode and pin
// - First filter averages the selected samples
`timescale 1ns/10ps
`default_nettype none
`include "tsi_defs.svh"
module tsi_top #(
  parameter logic [6:0] I2C_ADDR = `TSI_I2C_ADDR
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       afe_clk,
  output logic            pad2_out,
  output logic            pad2_oe_n,
  output logic [2:0]      ele_gnd,
  output logic [2:0]      ele_chg,
  output logic [5:0]      chg_current,
  output logic            adc_sample,
  output logic [1:0]      adc_ch,
  input  wire logic [9:0] adc_data
);
  import tsi_pkg::*;

  // Bus pin synchronisers and edge detection
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
    end
  end
  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // Registers and bus slave state
  tsi_bus_t   bst_r;
  logic [3:0] bitc_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic       rw_r, ptr_ph_r, drv_r, mack_r;
  logic [7:0] afe_r, filt_r;
  logic [3:0] elen_r;
  logic [2:0] status_r;

  wire [7:0] rdata_w =
    (ptr_r == `TSI_REG_STATUS) ? {5'h00, status_r} :
    (ptr_r == `TSI_REG_AFE)    ? afe_r :
    (ptr_r == `TSI_REG_FILT)   ? filt_r :
    (ptr_r == `TSI_REG_ELEN)   ? {4'h0, elen_r} : 8'h00;
  wire addr_hit = (sh_r[7:1] == I2C_ADDR);
  wire byte_end = (bitc_r == 4'h8);
  wire read_evt = scl_fall && (bst_r == B_ADDR) && byte_end && addr_hit && sh_r[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bst_r    <= B_IDLE;
      bitc_r   <= 4'h0;
      sh_r     <= 8'h00;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      ptr_ph_r <= 1'b0;
      drv_r    <= 1'b0;
      mack_r   <= 1'b0;
      afe_r    <= `TSI_AFE_RST;
      filt_r   <= `TSI_FILT_RST;
      elen_r   <= `TSI_ELEN_RST;
    end else if (bus_start) begin
      bst_r  <= B_ADDR;
      bitc_r <= 4'h0;
      drv_r  <= 1'b0;
    end else if (bus_stop) begin
      bst_r <= B_IDLE;
      drv_r <= 1'b0;
    end else if (scl_rise) begin
      if (bst_r == B_ADDR || bst_r == B_WDATA) begin
        sh_r   <= {sh_r[6:0], sda_s2_r};
        bitc_r <= bitc_r + 4'h1;
      end else if (bst_r == B_RDATA) begin
        bitc_r <= bitc_r + 4'h1;
      end else if (bst_r == B_ACKR) begin
        mack_r <= ~sda_s2_r;
      end
    end else if (scl_fall) begin
      case (bst_r)
        B_ADDR: if (byte_end) begin
          bst_r    <= addr_hit ? B_ACKA : B_IDLE;
          drv_r    <= addr_hit;
          rw_r     <= sh_r[0];
          ptr_ph_r <= 1'b1;
        end
        B_WDATA: if (byte_end) begin
          bst_r    <= B_ACKW;
          drv_r    <= 1'b1;
          ptr_ph_r <= 1'b0;
          if (ptr_ph_r) begin
            ptr_r <= sh_r;
          end else begin
            ptr_r <= ptr_r + 8'h01;
            if (ptr_r == `TSI_REG_AFE) begin
              afe_r <= sh_r;
            end else if (ptr_r == `TSI_REG_FILT) begin
              filt_r <= sh_r;
            end else if (ptr_r == `TSI_REG_ELEN) begin
              elen_r <= sh_r[`TSI_ELEN_MSB:0];
            end
          end
        end
        B_ACKA, B_ACKW: begin
          bitc_r <= 4'h0;
          if (bst_r == B_ACKA && rw_r) begin
            bst_r <= B_RDATA;
            sh_r  <= rdata_w;
            drv_r <= ~rdata_w[7];
            ptr_r <= ptr_r + 8'h01;
          end else begin
            bst_r <= B_WDATA;
            drv_r <= 1'b0;
          end
        end
        B_RDATA: begin
          if (byte_end) begin
            bst_r <= B_ACKR;
            drv_r <= 1'b0;
          end else begin
            sh_r  <= {sh_r[6:0], 1'b0};
            drv_r <= ~sh_r[6];
          end
        end
        B_ACKR: begin
          bitc_r <= 4'h0;
          bst_r  <= mack_r ? B_RDATA : B_IDLE;
          sh_r   <= rdata_w;
          drv_r  <= mack_r & ~rdata_w[7];
          ptr_r  <= mack_r ? ptr_r + 8'h01 : ptr_r;
        end
        default: bst_r <= B_IDLE;
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_r;

  // Mode and front end decode
  wire [5:0] cdc_w = afe_r[`TSI_CDC_MSB:`TSI_CDC_LSB];
  wire [1:0] ffi_w = afe_r[`TSI_FFI_MSB:`TSI_FFI_LSB];
  wire [2:0] cdt_w = filt_r[`TSI_CDT_MSB:`TSI_CDT_LSB];
  wire [1:0] n_ele_w = (elen_r == 4'h0) ? 2'd0 :
                       (elen_r == 4'h1) ? 2'd1 :
                       (elen_r == 4'h2) ? 2'd2 : 2'd3;
  wire irq_mode_w = (n_ele_w != 2'd3);
  wire [2:0] en_mask_w = (n_ele_w == 2'd0) ? 3'h0 : (n_ele_w == 2'd1) ? 3'h1 :
                         (n_ele_w == 2'd2) ? 3'h3 : 3'h7;
  wire [5:0] nsamp_w = (ffi_w == 2'h0) ? `TSI_FFI_N0 : (ffi_w == 2'h1) ? `TSI_FFI_N1 :
                       (ffi_w == 2'h2) ? `TSI_FFI_N2 : `TSI_FFI_N3;
  wire [9:0] t_cyc_w = 10'(`TSI_CHG_BASE_CYC) << (cdt_w - 3'h1);
  wire run_w = (n_ele_w != 2'd0) && (cdc_w != 6'h00) && (cdt_w != 3'h0);

  // Measurement sequencer
  tsi_seq_t     st_r;
  logic [9:0]   cnt_r;
  logic [1:0]   ch_r;
  logic [5:0]   samp_r;
  logic [15:0]  sum_r;
  logic         req_tgl_r;
  logic         done_w;
  tsi_adc_rsp_t rsp_w;
  tsi_adc_req_t req_w;
  assign req_w.ch = ch_r;

  wire cnt_zero = (cnt_r == 10'h000);
  wire last_samp = (samp_r == nsamp_w - 6'h01);
  wire upd_w = (st_r == S_DIS) && cnt_zero && last_samp;
  wire [15:0] avg_w = sum_r / {10'h000, nsamp_w};
  wire touch_w = (avg_w[9:0] < `TSI_TOUCH_LEVEL) && (avg_w[15:10] == 6'h00);
  wire [1:0] ch_next_w = (ch_r + 2'd1 >= n_ele_w) ? 2'd0 : ch_r + 2'd1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= S_IDLE;
      cnt_r     <= 10'h000;
      ch_r      <= 2'd0;
      samp_r    <= 6'h00;
      sum_r     <= 16'h0000;
      req_tgl_r <= 1'b0;
    end else if (!run_w && st_r != S_CONV) begin
      st_r   <= S_IDLE;
      samp_r <= 6'h00;
      sum_r  <= 16'h0000;
    end else begin
      case (st_r)
        S_IDLE: begin
          st_r  <= S_GND;
          cnt_r <= t_cyc_w - 10'h001;
          ch_r  <= (ch_r >= n_ele_w) ? 2'd0 : ch_r;
        end
        S_GND: begin
          st_r  <= cnt_zero ? S_CHG : S_GND;
          cnt_r <= cnt_zero ? t_cyc_w - 10'h001 : cnt_r - 10'h001;
        end
        S_CHG: begin
          cnt_r <= cnt_r - 10'h001;
          if (cnt_zero) begin
            st_r      <= S_CONV;
            req_tgl_r <= ~req_tgl_r;
          end
        end
        S_CONV: if (done_w) begin
          st_r  <= S_DIS;
          cnt_r <= t_cyc_w - 10'h001;
          sum_r <= sum_r + {6'h00, rsp_w.data};
        end
        S_DIS: begin
          cnt_r <= cnt_zero ? t_cyc_w - 10'h001 : cnt_r - 10'h001;
          if (cnt_zero) begin
            st_r   <= last_samp ? S_IDLE : S_GND;
            samp_r <= last_samp ? 6'h00 : samp_r + 6'h01;
            sum_r  <= last_samp ? 16'h0000 : sum_r;
            ch_r   <= last_samp ? ch_next_w : ch_r;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  tsi_adc_xfer u_xfer (
    .clk        (clk),
    .rst_n      (rst_n),
    .afe_clk    (afe_clk),
    .req_tgl    (req_tgl_r),
    .req        (req_w),
    .done       (done_w),
    .rsp        (rsp_w),
    .adc_sample (adc_sample),
    .adc_ch     (adc_ch),
    .adc_data   (adc_data)
  );

  // Electrode drive: only the measured electrode is released from ground
  wire meas_w = (st_r == S_CHG) || (st_r == S_CONV);
  logic [2:0] stat_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ele
      assign ele_gnd[gi] = !(meas_w && ch_r == 2'(gi));
      assign ele_chg[gi] = (st_r == S_CHG) && (ch_r == 2'(gi)) && (cdc_w != 6'h00);
      assign stat_nxt[gi] = en_mask_w[gi] &
        ((upd_w && ch_r == 2'(gi)) ? touch_w : status_r[gi]);
    end
  endgenerate
  assign chg_current = cdc_w;

  // Touch status and latching interrupt
  logic irq_r;
  wire stat_chg_w = (stat_nxt != status_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 3'h0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= stat_nxt;
      irq_r    <= irq_mode_w & (stat_chg_w | (irq_r & ~read_evt));
    end
  end
  assign pad2_out = 1'b0;
  assign pad2_oe_n = irq_mode_w ? ~irq_r : ~ele_gnd[2];

  // Conversions taken in the current averaging round
  logic [5:0] conv_n_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_n_r <= 6'h00;
    end else if (st_r == S_IDLE || upd_w) begin
      conv_n_r <= 6'h00;
    end else if (st_r == S_CONV && done_w) begin
      conv_n_r <= conv_n_r + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence conv_done_s;
    (st_r == S_CONV) && done_w && run_w;
  endsequence

  irq_set_a: assert property (stat_chg_w && irq_mode_w |=> !pad2_oe_n)
    else $error("Status change did not drive interrupt low");
  irq_hold_a: assert property (irq_r && !read_evt && irq_mode_w |=> irq_r)
    else $error("Interrupt released without a read");
  irq_release_a: assert property (read_evt && !stat_chg_w |=>
    !irq_r && (pad2_oe_n || !irq_mode_w))
    else $error("Read did not release interrupt");
  pin_mode_a: assert property (!irq_mode_w |=> !irq_r)
    else $error("Interrupt latched in electrode mode");
  others_gnd_a: assert property (meas_w |-> ($countones(ele_gnd) == 2) && !ele_gnd[ch_r])
    else $error("Non measured electrode not grounded");
  pre_ground_a: assert property ($rose(st_r == S_CHG) |-> $past(st_r) == S_GND)
    else $error("Charge started without grounding");
  charge_len_a: assert property ($rose(st_r == S_CHG) && run_w |-> cnt_r == t_cyc_w - 10'h001)
    else $error("Charge time not loaded");
  conv_dis_a: assert property (conv_done_s |=> (st_r == S_DIS) && (cnt_r == $past(t_cyc_w) - 10'h001))
    else $error("Discharge not matched to charge time");
  no_charge_a: assert property (cdc_w == 6'h00 |-> ele_chg == 3'h0)
    else $error("Charging with current code zero");
  avg_count_a: assert property (upd_w && run_w |-> conv_n_r == nsamp_w)
    else $error("Average taken over wrong sample count");
endmodule
`default_nettype wire

// >>> test/tsi_host_model.sv
// Host side model: register writes and reads on the two-wire port
`timescale 1ns/10ps
`default_nettype none
`include "tsi_defs.svh"
module tsi_host_model #(
  parameter logic [6:0] ADDR = `TSI_I2C_ADDR
) (
  input  wire logic  clk,
  input  wire logic  sda_in,
  output logic       scl,
  output logic       sda_low,
  output logic [7:0] rd_byte,
  output logic       rd_valid
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_byte = 8'h00;
    rd_valid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Data falls while the clock is high; also serves as a repeated start
  task automatic start();
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  // Eight bits MSB first, then the ninth bit with the line released
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= -1; i--) begin
      sda_low = (i >= 0) && !d[i];
      tick(4);
      scl = 1'b1;
      tick(4);
      if (i >= 0) r[i] = sda_in;
      scl = 1'b0;
      tick(2);
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, r);
    xfer(a, r);
    xfer(d, r);
    stop();
  endtask
  // Reads register a through the pointer then a read phase
  task automatic read_reg(input logic [7:0] a);
    logic [7:0] r;
    start();
    xfer({ADDR, 1'b0}, r);
    xfer(a, r);
    start();
    xfer({ADDR, 1'b1}, r);
    xfer(8'hff, r);
    stop();
    rd_byte = r;
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/test_tsi_top.sv
// Bench for the touch sense controller
`timescale 1ns/10ps
`default_nettype none
`include "tsi_defs.svh"
module test_tsi_top;
  logic       clk, rst_n, afe_clk, scl, sda_low, sda_out, sda_oe_n, pad2_out, pad2_oe_n;
  logic       adc_sample, rd_valid, elen3, alt;
  logic [1:0] adc_ch;
  logic [2:0] ele_gnd, ele_chg;
  logic [5:0] chg_current;
  logic [7:0] rd_byte, d;
  logic [9:0] adc_data;
  logic [9:0] lvl [3];
  logic [7:0] exp_q [$];
  int         n_errors, checked, seed, chg_cnt, exp_t;
  wire logic  sda_line;
  assign sda_line = !(sda_low || sda_oe_n === 1'b0);

  tsi_top uut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .afe_clk(afe_clk), .pad2_out(pad2_out), .pad2_oe_n(pad2_oe_n),
    .ele_gnd(ele_gnd), .ele_chg(ele_chg), .chg_current(chg_current),
    .adc_sample(adc_sample), .adc_ch(adc_ch), .adc_data(adc_data)
  );
  tsi_host_model host (
    .clk(clk), .sda_in(sda_line), .scl(scl), .sda_low(sda_low),
    .rd_byte(rd_byte), .rd_valid(rd_valid)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    afe_clk = 1'b0;
    #13;
    forever #80 afe_clk = ~afe_clk;
  end
  // Converter: alternate samples sit 0x20 either side of the level
  always @(negedge afe_clk) begin
    if (adc_sample === 1'b1) begin
      adc_data <= alt ? lvl[adc_ch] + 10'h020 : lvl[adc_ch] - 10'h020;
      alt <= !alt;
    end else begin
      adc_data <= ~adc_data;
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.read_reg(a);
  endtask
  task automatic wait_irq();
    int i;
    i = 0;
    while (pad2_oe_n !== 1'b0 && i < 40000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 40000) begin
      n_errors++;
      print_verdict();
    end
    #2;
  endtask

  always @(posedge rd_valid) begin
    chk(rd_byte, exp_q.pop_front());
  end
  // Pin watch: grounding, charge length, shared pin use
  always @(negedge clk) begin
    if (rst_n) begin
      chk(8'(ele_chg & ele_gnd), 8'h00);
      chk(8'($countones(~ele_gnd) <= 1), 8'h01);
      if (chg_current === 6'h00) chk(8'(ele_chg), 8'h00);
      if (elen3) chk({7'h00, pad2_oe_n}, {7'h00, !ele_gnd[2]});
      chk({6'h00, sda_out, pad2_out}, 8'h00);
      if (ele_chg !== 3'b000) chg_cnt++;
      else if (chg_cnt != 0) begin
        // A charge cut short by a stop grounds every electrode at once
        if (ele_gnd !== 3'b111) chk(8'(chg_cnt), 8'(exp_t));
        chg_cnt = 0;
      end
    end
  end

  initial begin
    n_errors = 0;
    checked = 0;
    seed = 32'h1dae188a;
    chg_cnt = 0;
    exp_t = 10;
    elen3 = 1'b0;
    alt = 1'b0;
    adc_data = 10'h000;
    lvl = '{10'h300, 10'h300, 10'h300};
    rst_n = 1'b0;
    repeat (2) @(posedge afe_clk);
    repeat (2) @(posedge clk);
    #2;
    chk(8'(pad2_oe_n), 8'h01);
    chk(8'(ele_gnd), 8'h07);
    rst_n = 1'b1;
    host.tick(3);
    rd(`TSI_REG_AFE, `TSI_AFE_RST);
    for (int k = 0; k < 4; k++) begin
      d = {2'(k), 6'($random(seed))};
      host.write_reg(`TSI_REG_AFE, d);
      rd(`TSI_REG_AFE, d);
      chk(8'(chg_current), {2'b00, d[5:0]});
    end
    rd(8'h10, 8'h00);
    host.write_reg(`TSI_REG_AFE, 8'h00);
    host.write_reg(`TSI_REG_ELEN, 8'h02);
    host.tick(500);
    lvl[0] = 10'h1e0 - (10'($random(seed)) & 10'h01f);
    lvl[1] = 10'h240 + (10'($random(seed)) & 10'h0ff);
    host.write_reg(`TSI_REG_AFE, 8'h01);
    wait_irq();
    host.tick(300);
    chk(8'(pad2_oe_n), 8'h00);
    rd(`TSI_REG_STATUS, 8'h01);
    chk(8'(pad2_oe_n), 8'h01);
    lvl[0] = 10'h240 + (10'($random(seed)) & 10'h0ff);
    wait_irq();
    rd(`TSI_REG_STATUS, 8'h00);
    chk(8'(pad2_oe_n), 8'h01);
    host.write_reg(`TSI_REG_ELEN, 8'h00);
    host.write_reg(`TSI_REG_FILT, 8'h40);
    exp_t = 20;
    lvl[2] = 10'h1e0 - (10'($random(seed)) & 10'h01f);
    host.write_reg(`TSI_REG_ELEN, 8'h03);
    elen3 = 1'b1;
    host.tick(4000);
    rd(`TSI_REG_STATUS, 8'h04);
    print_verdict();
  end
endmodule
`default_nettype wire
